/* inc/pin_cfg_pkg.sv */
// Constants shared by the pin function select and drive block.
// Assumes a byte-wide register port and one system clock domain.

package pin_cfg_pkg;

    // Register indices on the plain register port
    localparam logic [4:0] IDX_DRIVE2 = 5'h00;
    localparam logic [4:0] IDX_DRIVE3 = 5'h01;
    localparam logic [4:0] IDX_POWER = 5'h02;
    localparam logic [4:0] IDX_PA_LO = 5'h03;
    localparam logic [4:0] IDX_PA_HI = 5'h04;
    localparam logic [4:0] IDX_PB_LO = 5'h05;
    localparam logic [4:0] IDX_PB_HI = 5'h06;
    localparam logic [4:0] IDX_PC_LO = 5'h07;
    localparam logic [4:0] IDX_PC_HI = 5'h08;
    localparam logic [4:0] IDX_PD_LO = 5'h09;
    localparam logic [4:0] IDX_PD_HI = 5'h0a;
    localparam logic [4:0] IDX_PE_LO = 5'h0b;
    localparam logic [4:0] IDX_PE_HI = 5'h0c;
    localparam logic [4:0] IDX_PF_LO = 5'h0d;
    localparam logic [4:0] IDX_PF_HI = 5'h0e;
    localparam logic [4:0] IDX_PG_LO = 5'h0f;
    localparam logic [4:0] IDX_PG_HI = 5'h10;
    localparam logic [4:0] IDX_IN_SRC0 = 5'h11;
    localparam logic [4:0] IDX_IN_SRC2 = 5'h12;
    localparam logic [4:0] IDX_IN_SRC3 = 5'h13;
    localparam logic [4:0] IDX_IN_SRC4 = 5'h14;
    localparam int NUM_REGS = 21;

    // Implemented-bit masks
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_DRIVE3 = 8'h3f;
    localparam logic [7:0] MASK_POWER = 8'h03;
    localparam logic [7:0] MASK_PD_HI = 8'h3f;
    localparam logic [7:0] MASK_IN_SRC = 8'h7f;
    localparam logic [7:0] MASK_IN_SRC4 = 8'h03;

    // Reset value of every register
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // Field position of the supply select upper bit
    localparam int POWER_AUX_BIT = 1;

    // Drive strength codes
    localparam logic [1:0] DRIVE_MIN = 2'h0;
    localparam logic [1:0] DRIVE_MAX = 2'h3;

    // Pin function selector codes
    localparam logic [1:0] SEL_00 = 2'h0;
    localparam logic [1:0] SEL_01 = 2'h1;
    localparam logic [1:0] SEL_10 = 2'h2;
    localparam logic [1:0] SEL_11 = 2'h3;

    // Pin function routed to a pin
    typedef enum logic [3:0] {
        FN_GPIO = 4'h0,
        FN_SERIAL = 4'h1,
        FN_ANALOG = 4'h2,
        FN_LCD_SEG = 4'h3,
        FN_UART0 = 4'h4,
        FN_TIMER_OUT = 4'h5,
        FN_CMP0_OUT = 4'h6,
        FN_CRYSTAL = 4'h7,
        FN_VREF = 4'h8,
        FN_RESERVED = 4'h9
    } pin_fn_t;

endpackage

/* logic/pin_func_decode.sv */
// Decodes one port function selector byte into four pin function classes.
// Assumes a fixed per-port code table picked by the port parameter.
`timescale 1ns/100ps
`default_nettype none

module pin_func_decode #(
    parameter int PORT_ID = 0
) (
    input wire logic [7:0] sel,
    output pin_cfg_pkg::pin_fn_t fn [4]
);

    ////////////////////////////////////////////////////////////////////////
    // Code table, port id = 2*port + half, pin = field index
    function automatic pin_cfg_pkg::pin_fn_t code_fn(input int port,
                                                     input int pin,
                                                     input logic [1:0] c);
        pin_cfg_pkg::pin_fn_t f;
        f = pin_cfg_pkg::FN_GPIO;
        if (c == pin_cfg_pkg::SEL_11) begin
            f = pin_cfg_pkg::FN_LCD_SEG;
        end
        unique case (port)
            0: begin
                // [RL13] [RL14] port A low pins
                if (pin == 3 || pin == 1) begin
                    if (c == pin_cfg_pkg::SEL_01) begin
                        f = pin_cfg_pkg::FN_SERIAL;
                    end
                    if (c == pin_cfg_pkg::SEL_10) begin
                        f = pin_cfg_pkg::FN_ANALOG;
                    end
                end
            end
            1: begin
                // [RL15] [RL16] port A high pins
                if (pin >= 2 && c == pin_cfg_pkg::SEL_10) begin
                    f = pin_cfg_pkg::FN_UART0;
                end
                if (pin < 2 && c == pin_cfg_pkg::SEL_01) begin
                    f = pin_cfg_pkg::FN_SERIAL;
                end
                if (pin < 2 && c == pin_cfg_pkg::SEL_10) begin
                    f = pin_cfg_pkg::FN_ANALOG;
                end
            end
            2: begin
                // [RL17] [RL18] port B low pins
                if (pin >= 2 && c == pin_cfg_pkg::SEL_10) begin
                    f = pin_cfg_pkg::FN_TIMER_OUT;
                end
                if (pin == 0 && c == pin_cfg_pkg::SEL_10) begin
                    f = pin_cfg_pkg::FN_CMP0_OUT;
                end
            end
            3: begin
                // [RL19] [RL20] port B high pins
                if (pin >= 2 && c == pin_cfg_pkg::SEL_10) begin
                    f = pin_cfg_pkg::FN_CRYSTAL;
                end
                if (pin == 2 && c == pin_cfg_pkg::SEL_01) begin
                    f = pin_cfg_pkg::FN_TIMER_OUT;
                end
                if (pin == 0 && c == pin_cfg_pkg::SEL_10) begin
                    f = pin_cfg_pkg::FN_RESERVED;
                end
            end
            4: begin
                // [RL21] [RL22] port C low pins
                if (pin == 3) begin
                    if (c == pin_cfg_pkg::SEL_01) begin
                        f = pin_cfg_pkg::FN_TIMER_OUT;
                    end
                    if (c == pin_cfg_pkg::SEL_10) begin
                        f = pin_cfg_pkg::FN_ANALOG;
                    end
                end
                if (pin == 2) begin
                    if (c == pin_cfg_pkg::SEL_01) begin
                        f = pin_cfg_pkg::FN_ANALOG;
                    end
                    if (c == pin_cfg_pkg::SEL_10) begin
                        f = pin_cfg_pkg::FN_TIMER_OUT;
                    end
                end
                if (pin == 1) begin
                    if (c == pin_cfg_pkg::SEL_01) begin
                        f = pin_cfg_pkg::FN_VREF;
                    end
                    if (c == pin_cfg_pkg::SEL_10) begin
                        f = pin_cfg_pkg::FN_ANALOG;
                    end
                    if (c == pin_cfg_pkg::SEL_11) begin
                        f = pin_cfg_pkg::FN_CMP0_OUT;
                    end
                end
                if (pin == 0) begin
                    if (c == pin_cfg_pkg::SEL_01) begin
                        f = pin_cfg_pkg::FN_VREF;
                    end
                    if (c == pin_cfg_pkg::SEL_10) begin
                        f = pin_cfg_pkg::FN_ANALOG;
                    end
                end
            end
            default: begin
                f = pin_cfg_pkg::FN_GPIO;
            end
        endcase
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // One decoder per 2-bit field
    for (genvar i = 0; i < 4; i++) begin : g_field
        assign fn[i] = code_fn(PORT_ID, i, sel[2*i+1:2*i]);
    end

endmodule
`default_nettype wire

/* logic/pin_function_select_and_drive.sv */
// Pin function selection, drive strength and port E0 supply select.
// Assumes software on a plain byte port; pin direction comes from port logic.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RL1] Drive fields code levels 0..3; third register low field sets C3..C0
// [RL2] Third drive register fields drive F7..4, F2, E7..4 and E0
// [RL3] Fourth drive register drives G7..4, G3..0; bits 7..6 read zero
// [RL4] Software keeps fourth drive register bits 5..4 at reset value
// [RL5] Drive fields act only on pins that are push-pull outputs
// [RL6] Supply select upper bit picks main or auxiliary supply for E0
// [RL7] Software selects E4 auxiliary supply function before supply select
// [RL8] Supply choice only acts while E0 has a digital function
// [RL9] Supply select register bits 7..2 always read zero
// [RL10] Software sets selector, then configures and enables peripheral
// [RL11] Shared-code digital inputs also need direction set to input
// [RL12] Software disables peripheral before changing the selector
// [RL13] Port A pins 3 and 1 select GPIO, serial, analog or segment
// [RL14] Port A pins 2 and 0 are GPIO except code 11 segment
// [RL15] Port A pins 7 and 6 give GPIO, UART0 or segment
// [RL16] Port A pins 5 and 4 give GPIO, serial, analog or segment
// [RL17] Port B pins 3 and 2 give GPIO, timer output or segment
// [RL18] Port B pin 1 GPIO or segment; pin 0 adds comparator output
// [RL19] Port B pins 7 and 6 give GPIO, crystal or segment; pin 6 adds timer
// [RL20] Port B pin 5 GPIO or segment; pin 4 code 10 reserved
// [RL21] Port C pins 3 and 2 give GPIO, timer out, analog, segment
// [RL22] Port C pin 1 gives GPIO, reference, analog or comparator output
// [RL23] All registers clear to zero at reset
// [RL24] Selector registers read back last written implemented bits
module pin_function_select_and_drive (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_error,
    input wire logic [7:0] porta_output_mode,
    input wire logic [7:0] portb_output_mode,
    input wire logic [7:0] portc_output_mode,
    input wire logic [7:0] porte_output_mode,
    input wire logic [7:0] portf_output_mode,
    input wire logic [7:0] portg_output_mode,
    output logic [15:0] portc_drive_strength,
    output logic [15:0] porte_drive_strength,
    output logic [15:0] portf_drive_strength,
    output logic [15:0] portg_drive_strength,
    output logic pe0_aux_io_supply,
    output logic [31:0] porta_function,
    output logic [31:0] portb_function,
    output logic [15:0] portc_low_function
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [pin_cfg_pkg::NUM_REGS-1:0][7:0] regs;
        logic [7:0] rdata;
        logic error;
        logic [7:0][1:0] c_drv;
        logic [7:0][1:0] e_drv;
        logic [7:0][1:0] f_drv;
        logic [7:0][1:0] g_drv;
        logic aux;
        logic [7:0][3:0] a_fn;
        logic [7:0][3:0] b_fn;
        logic [3:0][3:0] c_fn;
    } state_t;

    state_t state;
    state_t next_state;
    logic [7:0] pin_out_a_s1;
    logic [7:0] pin_out_a;
    logic [7:0] pin_out_b_s1;
    logic [7:0] pin_out_b;
    logic [7:0] pin_out_c_s1;
    logic [7:0] pin_out_c;
    logic [7:0] pin_out_e_s1;
    logic [7:0] pin_out_e;
    logic [7:0] pin_out_f_s1;
    logic [7:0] pin_out_f;
    logic [7:0] pin_out_g_s1;
    logic [7:0] pin_out_g;
    pin_cfg_pkg::pin_fn_t dec_fn [5][4];

    ////////////////////////////////////////////////////////////////////////
    // Mask of implemented bits per register index
    function automatic logic [7:0] reg_mask(input logic [4:0] idx);
        logic [7:0] m;
        m = pin_cfg_pkg::MASK_FULL;
        unique case (idx)
            // [RL3] drive top bits absent
            pin_cfg_pkg::IDX_DRIVE3: m = pin_cfg_pkg::MASK_DRIVE3;
            // [RL9] supply select top bits absent
            pin_cfg_pkg::IDX_POWER: m = pin_cfg_pkg::MASK_POWER;
            pin_cfg_pkg::IDX_PD_HI: m = pin_cfg_pkg::MASK_PD_HI;
            pin_cfg_pkg::IDX_IN_SRC0: m = pin_cfg_pkg::MASK_IN_SRC;
            pin_cfg_pkg::IDX_IN_SRC2: m = pin_cfg_pkg::MASK_IN_SRC;
            pin_cfg_pkg::IDX_IN_SRC4: m = pin_cfg_pkg::MASK_IN_SRC4;
            default: m = pin_cfg_pkg::MASK_FULL;
        endcase
        return m;
    endfunction

    // Gate a drive field by push-pull output mode
    function automatic logic [1:0] gate_drive(input logic [1:0] fld,
                                              input logic push_pull);
        return push_pull ? fld : pin_cfg_pkg::DRIVE_MIN;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Output-mode inputs come from pad logic; two-stage synchronisers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_out_a_s1 <= 8'h00;
            pin_out_a <= 8'h00;
            pin_out_b_s1 <= 8'h00;
            pin_out_b <= 8'h00;
            pin_out_c_s1 <= 8'h00;
            pin_out_c <= 8'h00;
            pin_out_e_s1 <= 8'h00;
            pin_out_e <= 8'h00;
            pin_out_f_s1 <= 8'h00;
            pin_out_f <= 8'h00;
            pin_out_g_s1 <= 8'h00;
            pin_out_g <= 8'h00;
        end else begin
            pin_out_a_s1 <= porta_output_mode;
            pin_out_a <= pin_out_a_s1;
            pin_out_b_s1 <= portb_output_mode;
            pin_out_b <= pin_out_b_s1;
            pin_out_c_s1 <= portc_output_mode;
            pin_out_c <= pin_out_c_s1;
            pin_out_e_s1 <= porte_output_mode;
            pin_out_e <= pin_out_e_s1;
            pin_out_f_s1 <= portf_output_mode;
            pin_out_f <= pin_out_f_s1;
            pin_out_g_s1 <= portg_output_mode;
            pin_out_g <= pin_out_g_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Selector decoders for ports A, B and the low half of C
    for (genvar p = 0; p < 5; p++) begin : g_dec
        pin_func_decode #(
            .PORT_ID(p)
        ) u_dec (
            .sel(state.regs[pin_cfg_pkg::IDX_PA_LO + p]),
            .fn(dec_fn[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [7:0] d2;
        logic [7:0] d3;
        logic [7:0] r1;
        d2 = 8'h00;
        d3 = 8'h00;
        r1 = 8'h00;
        next_state = state;
        next_state.error = 1'b0;
        // [RL24] single-access write, masked
        if (reg_write) begin
            if (reg_addr < 5'(pin_cfg_pkg::NUM_REGS)) begin
                next_state.regs[reg_addr] = reg_wdata & reg_mask(reg_addr);
            end else begin
                next_state.error = 1'b1;
            end
        end
        // [RL24] read returns stored bits
        if (reg_read) begin
            if (reg_addr < 5'(pin_cfg_pkg::NUM_REGS)) begin
                next_state.rdata = state.regs[reg_addr];
            end else begin
                next_state.rdata = 8'h00;
                next_state.error = 1'b1;
            end
        end
        d2 = state.regs[pin_cfg_pkg::IDX_DRIVE2];
        d3 = state.regs[pin_cfg_pkg::IDX_DRIVE3];
        r1 = state.regs[pin_cfg_pkg::IDX_PC_LO + 1];
        for (int i = 0; i < 8; i++) begin
            // [RL1] [RL5] C3..C0 low field, gated
            next_state.c_drv[i] = i < 4 ? gate_drive(d2[1:0], pin_out_c[i])
                                        : pin_cfg_pkg::DRIVE_MIN;
            // [RL2] [RL5] port F and E fields
            next_state.f_drv[i] = (i >= 4) ? gate_drive(d2[7:6], pin_out_f[i])
                : (i == 2) ? gate_drive(d2[5:4], pin_out_f[i])
                : pin_cfg_pkg::DRIVE_MIN;
            next_state.e_drv[i] = (i >= 4) ? gate_drive(d2[3:2], pin_out_e[i])
                : (i == 0) ? gate_drive(d2[1:0], pin_out_e[i])
                : pin_cfg_pkg::DRIVE_MIN;
            // [RL3] [RL5] port G fields
            next_state.g_drv[i] = (i >= 4) ? gate_drive(d3[3:2], pin_out_g[i])
                : gate_drive(d3[1:0], pin_out_g[i]);
        end
        // Field pairs: lo register pins 3..0, hi register pins 7..4
        for (int i = 0; i < 4; i++) begin
            next_state.a_fn[i] = dec_fn[0][i];
            next_state.a_fn[i+4] = dec_fn[1][i];
            next_state.b_fn[i] = dec_fn[2][i];
            next_state.b_fn[i+4] = dec_fn[3][i];
            next_state.c_fn[i] = dec_fn[4][i];
        end
        // [RL6] [RL8] aux supply only with E0 on a digital function
        next_state.aux = state.regs[pin_cfg_pkg::IDX_POWER][
            pin_cfg_pkg::POWER_AUX_BIT]
            && (state.regs[pin_cfg_pkg::IDX_PE_LO][1:0]
                != pin_cfg_pkg::SEL_11);
        if (r1 == 8'hff) begin
            next_state.aux = next_state.aux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [RL23] state clears to zero
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from state
    assign reg_rdata = state.rdata;
    assign reg_error = state.error;
    assign portc_drive_strength = state.c_drv;
    assign porte_drive_strength = state.e_drv;
    assign portf_drive_strength = state.f_drv;
    assign portg_drive_strength = state.g_drv;
    assign pe0_aux_io_supply = state.aux;
    assign porta_function = state.a_fn;
    assign portb_function = state.b_fn;
    assign portc_low_function = state.c_fn;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_write_power;
        reg_write && reg_addr == pin_cfg_pkg::IDX_POWER;
    endsequence

    // [RL9] upper supply bits read zero
    property p_power_upper_zero;
        @(posedge clk_sys) disable iff (reset)
        reg_read && reg_addr == pin_cfg_pkg::IDX_POWER |=> reg_rdata[7:2] == 0;
    endproperty
    a_power_upper_zero: assert property (p_power_upper_zero) // [RL9]
        else $error("supply select upper bits not zero");

    // [RL3] drive3 top bits read zero
    property p_drive3_top_zero;
        @(posedge clk_sys) disable iff (reset)
        reg_read && reg_addr == pin_cfg_pkg::IDX_DRIVE3 |=> reg_rdata[7:6] == 0;
    endproperty
    a_drive3_top_zero: assert property (p_drive3_top_zero) // [RL3]
        else $error("drive3 top bits not zero");

    // [RL24] write then read returns data
    property p_readback;
        logic [4:0] a;
        logic [7:0] d;
        @(posedge clk_sys) disable iff (reset)
        (reg_write && !reg_read && reg_addr < 5'd21, a = reg_addr,
            d = reg_wdata & reg_mask(reg_addr))
        ##1 !reg_write
        ##1 (reg_read && reg_addr == a && !reg_write) |=> reg_rdata == d;
    endproperty
    a_readback: assert property (p_readback) // [RL24]
        else $error("readback differs from written value");

    // [RL6] supply select reaches output two cycles after write
    property p_aux_follow;
        @(posedge clk_sys) disable iff (reset)
        s_write_power ##1 (state.regs[pin_cfg_pkg::IDX_PE_LO][1:0] != 2'h3
            && !reg_write) |=> pe0_aux_io_supply == $past(reg_wdata[1], 2);
    endproperty
    a_aux_follow: assert property (p_aux_follow) // [RL6]
        else $error("supply select not followed");

    // [RL8] no aux supply while E0 is a segment
    property p_aux_digital;
        @(posedge clk_sys) disable iff (reset)
        $past(state.regs[pin_cfg_pkg::IDX_PE_LO][1:0]) == 2'h3
            |-> !pe0_aux_io_supply;
    endproperty
    a_aux_digital: assert property (p_aux_digital) // [RL8]
        else $error("aux supply with non digital function");

    // [RL5] drive zero for non output pin
    property p_drive_gate;
        @(posedge clk_sys) disable iff (reset)
        !pin_out_g[0] |=> portg_drive_strength[1:0] == 2'h0;
    endproperty
    a_drive_gate: assert property (p_drive_gate) // [RL5]
        else $error("drive applied to non output pin");

    // [RL1] C0 drive tracks low field when output
    property p_drive_c;
        @(posedge clk_sys) disable iff (reset)
        pin_out_c[0] |=> portc_drive_strength[1:0]
            == $past(state.regs[pin_cfg_pkg::IDX_DRIVE2][1:0]);
    endproperty
    a_drive_c: assert property (p_drive_c) // [RL1]
        else $error("port C drive wrong");

    // [RL13] code 11 on A3 gives segment
    property p_seg_a3;
        @(posedge clk_sys) disable iff (reset)
        state.regs[pin_cfg_pkg::IDX_PA_LO][7:6] == 2'h3
            |=> porta_function[15:12] == 4'h3;
    endproperty
    a_seg_a3: assert property (p_seg_a3) // [RL13]
        else $error("port A3 segment not selected");

    // [RL24] out-of-range read flags an error
    property p_range_error;
        @(posedge clk_sys) disable iff (reset)
        reg_read && reg_addr > 5'd20 |=> reg_error && reg_rdata == 8'h00;
    endproperty
    a_range_error: assert property (p_range_error) // [RL24]
        else $error("out of range read not flagged");

    // [RL2] E0 drive tracks its field when output
    property p_drive_e0;
        @(posedge clk_sys) disable iff (reset)
        pin_out_e[0] |=> porte_drive_strength[1:0]
            == $past(state.regs[pin_cfg_pkg::IDX_DRIVE2][1:0]);
    endproperty
    a_drive_e0: assert property (p_drive_e0) // [RL2]
        else $error("port E0 drive wrong");

    // [RL20] code 10 on B4 is flagged reserved
    property p_reserved_b4;
        @(posedge clk_sys) disable iff (reset)
        state.regs[pin_cfg_pkg::IDX_PB_HI][1:0] == 2'h2
            |=> portb_function[19:16] == pin_cfg_pkg::FN_RESERVED;
    endproperty
    a_reserved_b4: assert property (p_reserved_b4) // [RL20]
        else $error("port B4 reserved code not flagged");

endmodule
`default_nettype wire

/* test/pin_function_select_and_drive_bench.sv */
// Self-checking bench for pin function select, drive and supply select.
// Assumes the pin side model in its own file and the shared package.
`timescale 1ns/100ps
`default_nettype none

module pin_function_select_and_drive_bench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_error;
    logic [47:0] dir_req = 48'h0;
    logic [47:0] mode;
    logic [15:0] drv_c, drv_e, drv_f, drv_g, fn_c;
    logic [31:0] fn_a, fn_b;
    logic pe0_aux;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 32'h9474;
    logic [7:0] regs [21];
    // Code table per pin, nibble c is the function of selector code c
    localparam logic [15:0] FN_TAB [20] = '{16'h3000, 16'h3210, 16'h3000,
        16'h3210, 16'h3210, 16'h3210, 16'h3400, 16'h3400, 16'h3600, 16'h3000,
        16'h3500, 16'h3500, 16'h3900, 16'h3000, 16'h3750, 16'h3700, 16'h3280,
        16'h6280, 16'h3520, 16'h3250};

    ////////////////////////////////////////////////////////////////////////
    pin_side_model partner (.clk_sys(clk_sys), .dir_req(dir_req),
        .push_pull(mode));
    pin_function_select_and_drive dut (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_error(reg_error),
        .porta_output_mode(mode[7:0]), .portb_output_mode(mode[15:8]),
        .portc_output_mode(mode[23:16]), .porte_output_mode(mode[31:24]),
        .portf_output_mode(mode[39:32]), .portg_output_mode(mode[47:40]),
        .portc_drive_strength(drv_c), .porte_drive_strength(drv_e),
        .portf_drive_strength(drv_f), .portg_drive_strength(drv_g),
        .pe0_aux_io_supply(pe0_aux), .porta_function(fn_a),
        .portb_function(fn_b), .portc_low_function(fn_c));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz
    always #2.5 clk_sys = ~clk_sys;

    // Implemented bits of each register
    function automatic logic [7:0] mask_of(input logic [4:0] i);
        case (i)
            pin_cfg_pkg::IDX_DRIVE3, pin_cfg_pkg::IDX_PD_HI: return 8'h3f;
            pin_cfg_pkg::IDX_POWER, pin_cfg_pkg::IDX_IN_SRC4: return 8'h03;
            pin_cfg_pkg::IDX_IN_SRC0, pin_cfg_pkg::IDX_IN_SRC2: return 8'h7f;
            default: return 8'hff;
        endcase
    endfunction

    task automatic check(input string what, input logic [79:0] seen,
                         input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write, model updated with implemented bits only
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        if (a < 5'd21) regs[a] = d & mask_of(a);
    endtask

    // One-cycle read, data looked at in the following cycle only
    task automatic rd(input logic [4:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        check("rdata", reg_rdata, a < 5'd21 ? regs[a] : 8'h00);
        check("error", reg_error, a > 5'd20);
    endtask

    // Let writes and mode changes settle, then compare all derived outputs
    task automatic outs();
        logic [79:0] fexp;
        logic [47:0] dexp;
        logic [15:0] cexp;
        logic [1:0] c;
        logic aux;
        repeat (5) @(posedge clk_sys);
        #1;
        for (int k = 0; k < 20; k++) begin
            c = regs[3 + k / 4][2 * (k % 4) +: 2];
            fexp[4 * k +: 4] = FN_TAB[k][4 * c +: 4];
        end
        for (int p = 0; p < 8; p++) begin
            cexp[2*p +: 2] = p < 4 && dir_req[16+p] ? regs[0][1:0] : 2'h0;
            dexp[2*p +: 2] = p == 0 ? regs[0][1:0] :
                p > 3 ? regs[0][3:2] : 2'h0;
            dexp[16+2*p +: 2] = p == 2 ? regs[0][5:4] :
                p > 3 ? regs[0][7:6] : 2'h0;
            dexp[32+2*p +: 2] = p > 3 ? regs[1][3:2] : regs[1][1:0];
            for (int q = 0; q < 3; q++) begin
                if (!dir_req[8*(q+3)+p]) dexp[16*q+2*p +: 2] = 2'h0;
            end
        end
        aux = regs[2][1] && regs[pin_cfg_pkg::IDX_PE_LO][1:0] != 2'h3;
        check("function a", fn_a, fexp[31:0]);
        check("function b", fn_b, fexp[63:32]);
        check("function c", fn_c, fexp[79:64]);
        check("drive", {drv_g, drv_f, drv_e}, dexp);
        check("drive c", drv_c, cexp);
        check("supply", pe0_aux, aux);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        #20000;
        bad_count++;
        results();
    end

    initial begin
        logic [4:0] i;
        logic [7:0] d;
        logic [63:0] r;
        for (int k = 0; k < 21; k++) regs[k] = 8'h00;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        // Reset values, then unmapped places
        for (int k = 0; k < 23; k++) rd(k[4:0]);
        outs();
        // Every selector code on every function pin
        // peripherals stay off while selectors change
        for (int c = 0; c < 4; c++) begin
            for (int k = 3; k < 8; k++) wr(k[4:0], {4{c[1:0]}});
            outs();
        end
        dir_req <= 48'hffff_ffff_ffff;
        wr(pin_cfg_pkg::IDX_PE_HI, 8'h03);
        wr(pin_cfg_pkg::IDX_POWER, 8'h02);
        outs();
        wr(pin_cfg_pkg::IDX_PE_LO, 8'h03);
        outs();
        wr(pin_cfg_pkg::IDX_PE_LO, 8'h00);
        wr(pin_cfg_pkg::IDX_POWER, 8'h01);
        outs();
        wr(pin_cfg_pkg::IDX_POWER, 8'hff);
        rd(pin_cfg_pkg::IDX_POWER);
        outs();
        // Random registers and pin directions
        repeat (40) begin
            i = 5'($unsigned($random(seed)) % 21);
            d = 8'($random(seed));
            r = {$random(seed), $random(seed)};
            if (i == pin_cfg_pkg::IDX_DRIVE3) d[5:4] = 2'b00;
            dir_req <= r[47:0];
            wr(i, d);
            rd(i);
            outs();
        end
        // Second reset in mid-run clears everything
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        for (int k = 0; k < 21; k++) regs[k] = 8'h00;
        for (int k = 0; k < 21; k++) rd(k[4:0]);
        outs();
        results();
    end
endmodule

`default_nettype wire

/* test/pin_side_model.sv */
// Model of the port logic that reports which pins are push-pull outputs.
// Assumes the bench hands it the wanted pin directions; one system clock.
`timescale 1ns/100ps
`default_nettype none

module pin_side_model (
    input wire logic clk_sys,
    input wire logic [47:0] dir_req,
    output logic [47:0] push_pull
);
    // direction from port control
    // Pins set to input never report push-pull; changes land on an edge
    always @(posedge clk_sys) begin
        push_pull <= dir_req;
    end
endmodule

`default_nettype wire
